// ==== hw/irc_codec.sv ====
`timescale 1ns/1ps
// infrared short-pulse encoder and stretching decoder
module irc_codec
    import irc_pkg::*;
(
    input  wire logic ref_clk_i,
    input  wire logic reset_n_i,
    input  wire logic baud_clock_x16_i,
    input  wire logic uart_serial_out_i,
    input  wire logic decoder_reset_n_i,
    input  wire logic infrared_pulse_in_i,
    output logic      infrared_pulse_out_o,
    output logic      uart_serial_rx_out_o,
    output logic      encoder_ready_o
);

    logic           x16_prev;
    logic           tx_prev;
    logic [3:0]     phase;
    logic           ir_prev;
    logic [4:0]     stretch;
    irc_enc_state_e state;
    irc_enc_state_e next_state;
    logic [3:0]     enc_cnt;
    logic [3:0]     next_enc_cnt;
    logic           next_ir_out;
    logic           buf_in_ready;
    logic           buf_out_valid;
    irc_req_s       buf_out_data;
    irc_req_s       new_req;

    // x16 rising edge becomes a one-cycle tick; the input is already synchronous
    wire tick       = baud_clock_x16_i & ~x16_prev; // RQ4
    // a zero bit starts on a falling edge or every sixteen ticks while low
    wire tx_fall    = tick & tx_prev & ~uart_serial_out_i;
    wire zero_start = tick & ~uart_serial_out_i & (tx_prev | (phase == 4'h0)); // RQ1
    wire ir_fall    = tick & ir_prev & ~infrared_pulse_in_i; // RQ6
    // head leaves only when its pulse ends, since it carries the pulse timing
    wire pop        = (state == IRC_ENC_PULSE) & cnt_last;
    wire cnt_last   = tick & (enc_cnt == 4'h1);

    assign new_req.delay_ticks = IRC_ENC_DELAY_TICKS;
    assign new_req.pulse_ticks = IRC_ENC_PULSE_TICKS;

    // requests queue here so a busy encoder keeps one waiting zero bit; a start while both slots are full is dropped
    irc_pair_buffer #(
        .WIDTH ($bits(irc_req_s))
    ) u_req_buf (
        .ref_clk_i   (ref_clk_i),
        .reset_n_i   (reset_n_i),
        .in_valid_i  (zero_start),
        .in_ready_o  (buf_in_ready),
        .in_data_i   (new_req),
        .out_valid_o (buf_out_valid),
        .out_ready_i (pop),
        .out_data_o  (buf_out_data)
    );

    // tick detect and transmit bit phase
    always_ff @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            x16_prev <= 1'b0;
            tx_prev  <= 1'b1;
            phase    <= 4'h0;
        end else begin
            x16_prev <= baud_clock_x16_i;
            if (tick) begin
                tx_prev <= uart_serial_out_i;
                phase   <= tx_fall ? 4'h1 : phase + 4'h1; // wraps every 16 ticks
            end
        end
    end

    // encoder sequencing: wait, shine, return low
    always_comb begin
        next_state   = state;
        next_enc_cnt = enc_cnt;
        next_ir_out  = infrared_pulse_out_o;
        case (state)
            IRC_ENC_IDLE: begin
                if (buf_out_valid) begin
                    next_state   = IRC_ENC_DELAY;
                    next_enc_cnt = buf_out_data.delay_ticks;
                end
            end
            IRC_ENC_DELAY: begin
                if (cnt_last) begin
                    next_state   = IRC_ENC_PULSE;
                    next_enc_cnt = buf_out_data.pulse_ticks;
                    next_ir_out  = 1'b1; // RQ2
                end else if (tick) begin
                    next_enc_cnt = enc_cnt - 4'h1;
                end
            end
            IRC_ENC_PULSE: begin
                if (cnt_last) begin
                    next_state  = IRC_ENC_IDLE;
                    next_ir_out = 1'b0; // RQ3
                end else if (tick) begin
                    next_enc_cnt = enc_cnt - 4'h1;
                end
            end
            default: begin
                next_state  = IRC_ENC_IDLE;
                next_ir_out = IRC_IR_IDLE;
            end
        endcase
    end

    // pulse width is held in the popped entry, so the head must stay until done
    always_ff @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            state                <= IRC_ENC_IDLE;
            enc_cnt              <= 4'h0;
            infrared_pulse_out_o <= IRC_IR_IDLE; // RQ11
            encoder_ready_o      <= 1'b1;
        end else begin
            state                <= next_state;
            enc_cnt              <= next_enc_cnt;
            infrared_pulse_out_o <= next_ir_out;
            encoder_ready_o      <= buf_in_ready;
        end
    end

    // decoder: stretch each falling edge to one bit; its own reset blocks reception
    always_ff @(posedge ref_clk_i) begin
        if (!reset_n_i || !decoder_reset_n_i) begin // RQ9
            ir_prev              <= 1'b1;
            stretch              <= 5'h00;
            uart_serial_rx_out_o <= IRC_RX_IDLE; // RQ11
        end else if (ir_fall) begin
            stretch              <= IRC_BIT_TICKS; // RQ12
            uart_serial_rx_out_o <= 1'b0; // RQ7
            ir_prev              <= infrared_pulse_in_i;
        end else if (tick) begin
            ir_prev <= infrared_pulse_in_i;
            if (stretch != 5'h00) begin
                stretch <= stretch - 5'h01;
                if (stretch == 5'h01) begin
                    uart_serial_rx_out_o <= IRC_RX_IDLE; // RQ8
                end
            end
        end
    end

endmodule : irc_codec

// ==== hw/irc_pair_buffer.sv ====
`timescale 1ns/1ps
// two-entry buffer, valid and ready on both sides
module irc_pair_buffer
    import irc_pkg::*;
#(
    parameter int WIDTH = 8
) (
    input  wire logic             ref_clk_i,
    input  wire logic             reset_n_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic [WIDTH-1:0]      out_data_o
);

    logic [WIDTH-1:0] slot [IRC_BUF_DEPTH];
    logic [1:0]       count;
    logic             rd_ptr;
    logic             wr_ptr;
    wire              push = in_valid_i & in_ready_o;
    wire              pop  = out_valid_o & out_ready_i;

    // full and empty straight from the occupancy count
    assign in_ready_o  = (count != 2'h2);
    assign out_valid_o = (count != 2'h0);
    assign out_data_o  = slot[rd_ptr];

    // pointers and count; push and pop may share a cycle
    always_ff @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            count  <= 2'h0;
            rd_ptr <= 1'b0;
            wr_ptr <= 1'b0;
        end else begin
            if (push) begin
                slot[wr_ptr] <= in_data_i;
                wr_ptr       <= ~wr_ptr;
            end
            if (pop) begin
                rd_ptr <= ~rd_ptr;
            end
            count <= count + {1'b0, push} - {1'b0, pop};
        end
    end

endmodule : irc_pair_buffer

// ==== hw/irc_pkg.sv ====
// Functional notes
// RQ1: encoder emits one infrared pulse per zero bit, none for one bits.
// RQ2: after a transmit falling edge, wait seven x16 ticks before raising the pulse.
// RQ3: infrared pulse stays high three x16 ticks, then returns low.
// RQ4: all timing comes from rising edges of a clock at sixteen times baud.
// RQ5: system must supply the x16 clock where the UART provides none.
// RQ6: falling edge on infrared input marks arrival of one short pulse.
// RQ7: each received pulse drives serial receive low for sixteen x16 ticks.
// RQ8: stretched low interval lasts at least three quarters of a bit time.
// RQ9: active-low decoder reset clears decoder and blocks all reception while low.
// RQ10: x16 clock should stay at or below sixteen times 115.2 kbit/s.
// RQ11: serial receive idles high, also during decoder reset; infrared output idles low.
// RQ12: a new infrared edge during a stretch restarts the sixteen-tick count.
package irc_pkg;

    // encoder timing, in x16 ticks
    localparam logic [3:0] IRC_ENC_DELAY_TICKS = 4'h7;
    localparam logic [3:0] IRC_ENC_PULSE_TICKS = 4'h3;
    // decoder stretch length, one full bit time
    localparam logic [4:0] IRC_BIT_TICKS       = 5'h10;
    // reset levels of the pins
    localparam logic       IRC_RX_IDLE         = 1'b1;
    localparam logic       IRC_IR_IDLE         = 1'b0;
    localparam int         IRC_BUF_DEPTH       = 2;

    // one encoder job: how long to wait and how long to shine
    typedef struct packed {
        logic [3:0] delay_ticks;
        logic [3:0] pulse_ticks;
    } irc_req_s;

    typedef enum logic [1:0] {
        IRC_ENC_IDLE,
        IRC_ENC_DELAY,
        IRC_ENC_PULSE
    } irc_enc_state_e;

endpackage : irc_pkg

// ==== tb/irc_codec_properties.sv ====
`timescale 1ns/1ps
// tick-based view of both directions
module irc_codec_properties (
    input wire logic ref_clk_i,
    input wire logic reset_n_i,
    input wire logic baud_clock_x16_i,
    input wire logic uart_serial_out_i,
    input wire logic decoder_reset_n_i,
    input wire logic infrared_pulse_in_i,
    input wire logic infrared_pulse_out_o,
    input wire logic uart_serial_rx_out_o,
    input wire logic encoder_ready_o
);
    logic       xq, tq, iq;
    logic [4:0] d, r, c;
    wire        ir = infrared_pulse_out_o;
    wire        rx = uart_serial_rx_out_o;
    wire        tk = baud_clock_x16_i & !xq;
    // zero start: a falling edge, or still zero sixteen ticks on
    wire        zs = tk & !uart_serial_out_i & (tq | d == 5'hF);
    wire        fe = tk & !infrared_pulse_in_i & iq & decoder_reset_n_i;
    // d saturates so a long idle never fakes a repeat start
    always_ff @(posedge ref_clk_i) begin
        xq <= reset_n_i & baud_clock_x16_i;
        tq <= !reset_n_i | (tk ? uart_serial_out_i : tq);
        // decoder reset parks the last seen level high, as the codec does
        iq <= !reset_n_i | !decoder_reset_n_i | (tk ? infrared_pulse_in_i : iq);
        d  <= !reset_n_i ? 5'h1F : zs ? 5'h0 : d + {4'h0, tk & d != 5'h1F};
        c  <= ir ? c + {4'h0, tk} : 5'h0;
        r  <= rx | fe ? 5'h0 : r + {4'h0, tk};
    end
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!reset_n_i);
    chk_rx_fall: assert property (fe |=> !rx) else $error("rx late");
    chk_rx_cause: assert property ($fell(rx) |-> $past(fe)) else $error("rx stray");
    chk_rx_len: assert property ($rose(rx) && $past(decoder_reset_n_i) |-> r == 5'h10)
        else $error("rx length");
    chk_rx_reset: assert property (!decoder_reset_n_i |=> rx) else $error("rx reset");
    chk_ir_delay: assert property ($rose(ir) |-> d == 5'h7) else $error("ir delay");
    chk_ir_width: assert property ($fell(ir) |-> c == 5'h3) else $error("ir width");
    chk_ir_span: assert property (ir |-> d inside {[5'h7:5'h9]}) else $error("ir idle");
    chk_ir_each: assert property (zs |-> ##[1:450] $rose(ir)) else $error("ir lost");
endmodule : irc_codec_properties
bind irc_codec irc_codec_properties u_irc_codec_properties (
    .ref_clk_i            (ref_clk_i),
    .reset_n_i            (reset_n_i),
    .baud_clock_x16_i     (baud_clock_x16_i),
    .uart_serial_out_i    (uart_serial_out_i),
    .decoder_reset_n_i    (decoder_reset_n_i),
    .infrared_pulse_in_i  (infrared_pulse_in_i),
    .infrared_pulse_out_o (infrared_pulse_out_o),
    .uart_serial_rx_out_o (uart_serial_rx_out_o),
    .encoder_ready_o      (encoder_ready_o)
);

// ==== tb/irc_codec_test.sv ====
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin errors++; \
    $display("MISMATCH %0t %h %h", $time, g, e); end end
module irc_codec_test;
    logic ref_clk_i = 0, reset_n_i = 0, uart_serial_out_i = 1, decoder_reset_n_i = 1;
    logic infrared_pulse_in_i = 1, baud_clock_x16_i, infrared_pulse_out_o;
    logic uart_serial_rx_out_o, encoder_ready_o;
    int   errors = 0, cmp_count = 0;
    // 100 MHz system clock
    always #5 ref_clk_i = !ref_clk_i;
    // x16 source and the codec share the bench nets by name
    irc_x16_source u_irc_x16_source (
        .ref_clk_i        (ref_clk_i),
        .reset_n_i        (reset_n_i),
        .baud_clock_x16_o (baud_clock_x16_i)
    );
    irc_codec u_irc_codec (
        .ref_clk_i            (ref_clk_i),
        .reset_n_i            (reset_n_i),
        .baud_clock_x16_i     (baud_clock_x16_i),
        .uart_serial_out_i    (uart_serial_out_i),
        .decoder_reset_n_i    (decoder_reset_n_i),
        .infrared_pulse_in_i  (infrared_pulse_in_i),
        .infrared_pulse_out_o (infrared_pulse_out_o),
        .uart_serial_rx_out_o (uart_serial_rx_out_o),
        .encoder_ready_o      (encoder_ready_o)
    );
    task tick();
        @(posedge baud_clock_x16_i) @(posedge ref_clk_i);
    endtask : tick
    // a byte lsb first; every first bit is one, so no extra idle tick is needed
    task automatic enc(input logic [7:0] b);
        logic [8:0] p = {1'b1, b};
        for (int n = 0; n < 128; n++) begin
            tick();
            if (n % 16 == 15) uart_serial_out_i <= p[n / 16 + 1];
            #1;
            `CHK(infrared_pulse_out_o, !p[n / 16] && n % 16 inside {[7:9]})
            // at sixteen-tick spacing the request buffer never fills
            `CHK(encoder_ready_o, 1'b1)
        end
    endtask : enc
    // three-tick pulses open each zero; reset changes only while the line is high
    task automatic dec(input logic [7:0] b, input logic en);
        logic [8:0] p = {1'b1, b};
        int s = 99;
        tick();
        decoder_reset_n_i <= en;
        for (int n = 0; n < 128; n++) begin
            tick();
            if (n % 16 == 2 || n % 16 == 15) infrared_pulse_in_i <= n % 16 == 2 || p[n / 16 + 1];
            s = n % 16 == 0 && !p[n / 16] ? 0 : s + 1;
            #1;
            `CHK(uart_serial_rx_out_o, !(en && s < 16))
        end
    endtask : dec
    // runs of zeros, lone zeros, and reception held off
    initial begin
        repeat (5) @(posedge ref_clk_i);
        reset_n_i <= 1'b1;
        enc(8'hC3);
        enc(8'hA5);
        dec(8'hC3, 1'b1);
        dec(8'hA5, 1'b0);
        dec(8'hA5, 1'b1);
        conclude();
    end
    // the run needs about 0.36 ms; margin kept well under the cycle budget
    initial #600000 begin
        errors++;
        conclude();
    end
    task conclude();
        $display("errors %0d of %0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : conclude
endmodule : irc_codec_test

// ==== tb/irc_x16_source.sv ====
`timescale 1ns/1ps
// x16 source, held low in reset so the first tick comes clean
module irc_x16_source #(parameter int DIV = 56) (
    input  wire logic ref_clk_i,
    input  wire logic reset_n_i,
    output logic      baud_clock_x16_o
);
    int cnt;
    // 100 MHz over 56 stays under 16 x 115.2 kbit/s
    always_ff @(posedge ref_clk_i) begin
        cnt              <= !reset_n_i || cnt == DIV - 1 ? 0 : cnt + 1;
        baud_clock_x16_o <= reset_n_i && cnt >= DIV / 2;
    end
endmodule : irc_x16_source
